// ===== logic/cpd_cfg.svh
// Purpose: constants for the control and port opcode decoder
// Assumes: byte-wide opcodes, 16-bit address space
// Notes: definitions only
`ifndef CPD_CFG_SVH
`define CPD_CFG_SVH
// -----------------------------------------------------------------
// opcodes, first byte
// -----------------------------------------------------------------
`define CPD_OP_IDLE 8'h00
`define CPD_OP_HALT 8'h76
`define CPD_OP_MASK 8'hf3
`define CPD_OP_UNMASK 8'hfb
`define CPD_OP_PREFIX 8'hed
`define CPD_OP_IN_IMM 8'hdb
`define CPD_OP_OUT_IMM 8'hd3
// -----------------------------------------------------------------
// opcodes after the prefix, and field masks
// -----------------------------------------------------------------
`define CPD_OP_MODE0 8'h46
`define CPD_OP_MODE1 8'h56
`define CPD_OP_MODE2 8'h5e
`define CPD_IND_MASK 8'hc6
`define CPD_IND_MATCH 8'h40
`define CPD_BLK_MASK 8'he6
`define CPD_BLK_MATCH 8'ha2
`define CPD_RST_MASK 8'hc7
`define CPD_RST_MATCH 8'hc7
`define CPD_RST_TGT_MASK 8'h38
// -----------------------------------------------------------------
// register indices, reset values, fixed addresses
// -----------------------------------------------------------------
`define CPD_IDX_B 3'h0
`define CPD_IDX_C 3'h1
`define CPD_IDX_H 3'h4
`define CPD_IDX_L 3'h5
`define CPD_IDX_NONE 3'h6
`define CPD_IDX_A 3'h7
`define CPD_REG_RST 8'h00
`define CPD_PC_RST 16'h0000
`define CPD_SP_RST 16'h0000
`define CPD_MODE1_TGT 16'h0038
`define CPD_ONE16 16'h0001
`define CPD_TWO16 16'h0002
`define CPD_ONE8 8'h01
`define CPD_ZERO8 8'h00
`endif

// ===== logic/cpd_core.sv
// Purpose: executes control-group and port i/o opcodes of one processor
// Assumes: memory/io bus answers each request with a one-cycle ack
// Notes: opcodes outside the two groups (except restart) act as no-ops
`timescale 1ns/1ps
`include "cpd_cfg.svh"
module cpd_core
  import cpd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // memory and io bus
  output logic bus_req_r,
  output logic bus_wr_r,
  output logic bus_io_r,
  output logic [15:0] bus_addr_r,
  output logic [7:0] bus_wdata_r,
  input wire logic bus_ack,
  input wire logic [7:0] bus_rdata,
  // interrupt
  input wire logic irq_req,
  output logic irq_ack_r,
  // register preload and status
  input wire logic reg_ld,
  input wire logic [2:0] reg_sel,
  input wire logic [7:0] reg_din,
  output logic [15:0] pc_r,
  output logic halted_r,
  output logic irq_en_r,
  output logic [1:0] irq_mode_r
);
  // -----------------------------------------------------------------
  // state and datapath registers
  // -----------------------------------------------------------------
  cpd_state_e st_r, st_nxt;
  cpd_byte_t regs_r [0:7];
  cpd_byte_t reg_nxt [0:7];
  cpd_byte_t op_r, port_r, data_r, vec_r;
  logic [15:0] sp_r, tgt_r;

  // -----------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------
  // bus cycle ends on ack of a raised request
  wire cyc_done = bus_req_r & bus_ack;
  wire is_bus_st = (st_r != ST_HALT);
  wire irq_take = irq_req & irq_en_r & ~bus_req_r & ((st_r == ST_FETCH) | (st_r == ST_HALT));
  wire cyc_start = is_bus_st & ~bus_req_r & ~irq_take;
  // mode zero feeds the device byte through the same decoder
  wire dec_dev = (st_r == ST_IACK) & (irq_mode_r == CPD_MODE_ZERO);
  wire dec_go = cyc_done & ((st_r == ST_FETCH) | dec_dev);
  wire is_rst = (bus_rdata & `CPD_RST_MASK) == `CPD_RST_MATCH;
  wire io_imm = (op_r == `CPD_OP_IN_IMM) | (op_r == `CPD_OP_OUT_IMM);
  wire io_blk = (op_r & `CPD_BLK_MASK) == `CPD_BLK_MATCH;
  wire io_wr = io_imm ? (op_r == `CPD_OP_OUT_IMM) : op_r[0];
  wire blk_dn = op_r[3];
  wire blk_rep = op_r[4];
  wire [2:0] r_fld = op_r[5:3];
  wire is_ind = ((bus_rdata & `CPD_IND_MASK) == `CPD_IND_MATCH);
  wire is_blk = ((bus_rdata & `CPD_BLK_MASK) == `CPD_BLK_MATCH);
  wire prefix_done = (st_r == ST_PREFIX) & cyc_done;
  // block step ends after io write or memory write
  wire blk_done = cyc_done & (((st_r == ST_IO) & io_blk & io_wr) | (st_r == ST_MEMW));
  wire [7:0] b_dec = regs_r[`CPD_IDX_B] - `CPD_ONE8;
  wire [15:0] hl = {regs_r[`CPD_IDX_H], regs_r[`CPD_IDX_L]};
  wire [15:0] hl_nxt = blk_dn ? hl - `CPD_ONE16 : hl + `CPD_ONE16;
  // indirect reads to field 6 only touch the bus, no register
  wire wr_hit = (st_r == ST_IO) & cyc_done & ~io_wr & ~io_blk & (io_imm | (r_fld != `CPD_IDX_NONE));
  wire [2:0] wr_idx = io_imm ? `CPD_IDX_A : r_fld;
  wire [7:0] out_val = io_blk ? data_r : io_imm ? regs_r[`CPD_IDX_A] :
                       (r_fld == `CPD_IDX_NONE) ? `CPD_ZERO8 : regs_r[r_fld];
  wire [15:0] io_addr = io_imm ? {regs_r[`CPD_IDX_A], port_r} :
                        {regs_r[`CPD_IDX_B], regs_r[`CPD_IDX_C]};
  wire [15:0] vec_ptr = {regs_r[`CPD_IDX_NONE], vec_r};
  wire [15:0] sp_dec = sp_r - `CPD_ONE16;

  // address, direction and data for the cycle a state starts
  logic [15:0] cyc_addr;
  logic [7:0] cyc_wdata;
  logic cyc_wr, cyc_io;
  always_comb begin
    cyc_addr = pc_r;
    cyc_wdata = `CPD_ZERO8;
    cyc_wr = 1'b0;
    cyc_io = 1'b0;
    case (st_r)
      ST_IO: begin
        cyc_addr = io_addr;
        cyc_wr = io_wr;
        cyc_io = 1'b1;
        cyc_wdata = out_val;
      end
      ST_MEMW: begin
        cyc_addr = hl;
        cyc_wr = 1'b1;
        cyc_wdata = data_r;
      end
      ST_MEMR: cyc_addr = hl;
      ST_VLO: cyc_addr = vec_ptr;
      ST_VHI: cyc_addr = vec_ptr + `CPD_ONE16;
      ST_PUSHH: begin
        cyc_addr = sp_dec;
        cyc_wr = 1'b1;
        cyc_wdata = pc_r[15:8];
      end
      ST_PUSHL: begin
        cyc_addr = sp_dec;
        cyc_wr = 1'b1;
        cyc_wdata = pc_r[7:0];
      end
      default: cyc_addr = pc_r;
    endcase
  end

  // next state; the opcode byte is decoded where it arrives
  always_comb begin
    st_nxt = st_r;
    if (irq_take) begin
      st_nxt = ST_IACK;
    end else if (dec_go) begin
      if (bus_rdata == `CPD_OP_HALT) st_nxt = ST_HALT;
      else if (bus_rdata == `CPD_OP_PREFIX) st_nxt = ST_PREFIX;
      else if ((bus_rdata == `CPD_OP_IN_IMM) | (bus_rdata == `CPD_OP_OUT_IMM)) st_nxt = ST_IMM;
      else if (is_rst) st_nxt = ST_PUSHH;
      else st_nxt = ST_FETCH;
    end else if (cyc_done) begin
      case (st_r)
        ST_PREFIX: st_nxt = is_blk ? (bus_rdata[0] ? ST_MEMR : ST_IO) :
                            is_ind ? ST_IO : ST_FETCH;
        ST_IMM: st_nxt = ST_IO;
        ST_IO: st_nxt = (io_blk & ~io_wr) ? ST_MEMW : ST_FETCH;
        ST_MEMR: st_nxt = ST_IO;
        ST_MEMW: st_nxt = ST_FETCH;
        ST_IACK: st_nxt = (irq_mode_r == CPD_MODE_TWO) ? ST_VLO : ST_PUSHH;
        ST_VLO: st_nxt = ST_VHI;
        ST_VHI: st_nxt = ST_PUSHH;
        ST_PUSHH: st_nxt = ST_PUSHL;
        ST_PUSHL: st_nxt = ST_FETCH;
        default: st_nxt = ST_FETCH;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // register file, one entry per register; entry 6 is the vector page
  // -----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_reg
      localparam logic [2:0] IDX = 3'(gi);
      assign reg_nxt[gi] = (reg_ld & (reg_sel == IDX)) ? reg_din :
                           (wr_hit & (wr_idx == IDX)) ? bus_rdata :
                           (blk_done & (IDX == `CPD_IDX_B)) ? b_dec :
                           (blk_done & (IDX == `CPD_IDX_H)) ? hl_nxt[15:8] :
                           (blk_done & (IDX == `CPD_IDX_L)) ? hl_nxt[7:0] : regs_r[gi];
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) regs_r[gi] <= `CPD_REG_RST;
        else regs_r[gi] <= reg_nxt[gi];
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // sequencer, bus and program counter
  // -----------------------------------------------------------------
  // request holds its address until ack, so devices may stall freely
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= ST_FETCH;
      bus_req_r <= 1'b0;
      bus_wr_r <= 1'b0;
      bus_io_r <= 1'b0;
      bus_addr_r <= `CPD_PC_RST;
      bus_wdata_r <= `CPD_ZERO8;
      irq_ack_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (cyc_done) begin
        bus_req_r <= 1'b0;
        irq_ack_r <= 1'b0;
      end else if (cyc_start) begin
        bus_req_r <= 1'b1;
        bus_wr_r <= cyc_wr;
        bus_io_r <= cyc_io;
        bus_addr_r <= cyc_addr;
        bus_wdata_r <= cyc_wdata;
        irq_ack_r <= (st_r == ST_IACK);
      end
    end
  end

  // program counter, stack, latches
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_r <= `CPD_PC_RST;
      sp_r <= `CPD_SP_RST;
      tgt_r <= `CPD_PC_RST;
      op_r <= `CPD_ZERO8;
      port_r <= `CPD_ZERO8;
      data_r <= `CPD_ZERO8;
      vec_r <= `CPD_ZERO8;
    end else begin
      if (cyc_done & ((st_r == ST_FETCH) | (st_r == ST_PREFIX) | (st_r == ST_IMM)))
        pc_r <= pc_r + `CPD_ONE16; // device bytes in mode zero leave pc alone
      else if (blk_done & blk_rep & (b_dec != `CPD_ZERO8))
        pc_r <= pc_r - `CPD_TWO16; // re-run, interrupts can cut in
      else if ((st_r == ST_PUSHL) & cyc_done)
        pc_r <= tgt_r;
      if (cyc_done & ((st_r == ST_PUSHH) | (st_r == ST_PUSHL))) sp_r <= sp_dec;
      if (dec_go & is_rst) tgt_r <= {`CPD_ZERO8, bus_rdata & `CPD_RST_TGT_MASK};
      else if (cyc_done & (st_r == ST_IACK) & (irq_mode_r == CPD_MODE_ONE))
        tgt_r <= `CPD_MODE1_TGT;
      else if (cyc_done & (st_r == ST_VLO)) tgt_r[7:0] <= bus_rdata;
      else if (cyc_done & (st_r == ST_VHI)) tgt_r[15:8] <= bus_rdata;
      if (dec_go) op_r <= bus_rdata;
      else if (prefix_done) op_r <= bus_rdata;
      if (cyc_done & (st_r == ST_IMM)) port_r <= bus_rdata;
      if (cyc_done & (((st_r == ST_IO) & io_blk) | (st_r == ST_MEMR))) data_r <= bus_rdata;
      if (cyc_done & (st_r == ST_IACK)) vec_r <= bus_rdata;
    end
  end

  // interrupt enable, mode, halt status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_r <= 1'b0;
      irq_mode_r <= CPD_MODE_ZERO;
      halted_r <= 1'b0;
    end else begin
      if (irq_take) irq_en_r <= 1'b0;
      else if (dec_go & (bus_rdata == `CPD_OP_MASK)) irq_en_r <= 1'b0;
      else if (dec_go & (bus_rdata == `CPD_OP_UNMASK)) irq_en_r <= 1'b1;
      if (prefix_done & (bus_rdata == `CPD_OP_MODE0)) irq_mode_r <= CPD_MODE_ZERO;
      if (prefix_done & (bus_rdata == `CPD_OP_MODE1)) irq_mode_r <= CPD_MODE_ONE;
      if (prefix_done & (bus_rdata == `CPD_OP_MODE2)) irq_mode_r <= CPD_MODE_TWO;
      halted_r <= (st_nxt == ST_HALT);
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_IDLE_PC: assert property ((st_r == ST_FETCH) && cyc_done && !bus_io_r &&
    (bus_rdata == `CPD_OP_IDLE) |=> (st_r == ST_FETCH) && (pc_r == $past(pc_r) + `CPD_ONE16)
    && (irq_en_r == $past(irq_en_r))) else $error("idle opcode changed more than pc");
  AST_HALT_STAY: assert property ((st_r == ST_HALT) && !(irq_req && irq_en_r) |=>
    (st_r == ST_HALT) && halted_r && !bus_req_r) else $error("halt left without irq");
  AST_MASK: assert property (dec_go && (bus_rdata == `CPD_OP_MASK) |=> !irq_en_r)
    else $error("mask opcode left irq enabled");
  AST_MODE_HOLD: assert property (!prefix_done |=> $stable(irq_mode_r))
    else $error("irq mode changed outside mode select");
  AST_MODE1_CALL: assert property ((st_r == ST_IACK) && cyc_done &&
    (irq_mode_r == CPD_MODE_ONE) |=> (st_r == ST_PUSHH) ##1 bus_req_r && bus_wr_r &&
    (bus_wdata_r == pc_r[15:8])) else $error("mode one did not push");
  AST_MODE2_PTR: assert property ((st_r == ST_VLO) && bus_req_r |->
    (bus_addr_r == {regs_r[`CPD_IDX_NONE], vec_r})) else $error("bad vector pointer");
  AST_IMM_ADDR: assert property ((st_r == ST_IO) && bus_req_r && io_imm |->
    bus_io_r && (bus_addr_r == {regs_r[`CPD_IDX_A], port_r})) else $error("bad imm port addr");
  AST_IND_ADDR: assert property ((st_r == ST_IO) && bus_req_r && !io_imm |->
    (bus_addr_r == {regs_r[`CPD_IDX_B], regs_r[`CPD_IDX_C]})) else $error("bad ind port addr");
  AST_BLK_COUNT: assert property (blk_done && !reg_ld |=>
    regs_r[`CPD_IDX_B] == $past(regs_r[`CPD_IDX_B]) - 8'h01) else $error("count not stepped");
  AST_PUSH_JUMP: assert property ((st_r == ST_PUSHL) && cyc_done |=>
    (pc_r == $past(tgt_r)) && (st_r == ST_FETCH)) else $error("call target missed");
  CVR_HALT_WAKE: cover property ((st_r == ST_HALT) ##1 (st_r == ST_IACK));
  CVR_MODE2: cover property ((st_r == ST_VHI) && cyc_done);
  CVR_BLK_REPEAT: cover property (blk_done && blk_rep && (b_dec != 8'h00));
endmodule : cpd_core

// ===== logic/cpd_pkg.sv
// Purpose: types for the control and port opcode decoder
// Assumes: cpd_cfg.svh holds the numeric constants
// Notes: state codes are gray along fetch, prefix, port, memory
package cpd_pkg;
  // interrupt response modes
  typedef enum logic [1:0] {
    CPD_MODE_ZERO = 2'h0,
    CPD_MODE_ONE = 2'h1,
    CPD_MODE_TWO = 2'h2
  } cpd_mode_e;
  // sequencer states
  typedef enum logic [3:0] {
    ST_FETCH = 4'h0,
    ST_PREFIX = 4'h1,
    ST_IMM = 4'h3,
    ST_IO = 4'h2,
    ST_MEMW = 4'h6,
    ST_MEMR = 4'h7,
    ST_HALT = 4'h5,
    ST_IACK = 4'h4,
    ST_VLO = 4'hc,
    ST_VHI = 4'hd,
    ST_PUSHH = 4'hf,
    ST_PUSHL = 4'he
  } cpd_state_e;
  typedef logic [7:0] cpd_byte_t;
endpackage : cpd_pkg

// ===== verification/cpd_bus_model.sv
// Purpose: memory, io ports and interrupting device beside cpd_core
// Assumes: one request at a time, answered after ack_wait idle cycles
// Notes: read data toggles whenever the bus is not being answered
`timescale 1ns/1ps
module cpd_bus_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus from the core
  input wire logic bus_req_r,
  input wire logic bus_wr_r,
  input wire logic bus_io_r,
  input wire logic [15:0] bus_addr_r,
  input wire logic [7:0] bus_wdata_r,
  input wire logic irq_ack_r,
  output logic bus_ack,
  output logic [7:0] bus_rdata,
  // bench controls
  input wire logic [3:0] ack_wait,
  input wire logic [7:0] irq_vec,
  input wire logic ld_en,
  input wire logic [15:0] ld_addr,
  input wire logic [7:0] ld_data
);
  logic [7:0] mem [0:65535];
  logic [3:0] cnt_r;
  // io ports answer with a value the bench can predict from the address
  wire logic [7:0] io_val = bus_addr_r[7:0] ^ bus_addr_r[15:8];
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  // bench loads win; the core is idle whenever the bench loads
  always @(posedge clk) begin
    if (ld_en) mem[ld_addr] <= ld_data;
    else if (bus_ack && bus_req_r && bus_wr_r && !bus_io_r) mem[bus_addr_r] <= bus_wdata_r;
  end
  // ---------------------------------------------------------------
  // answer
  // ---------------------------------------------------------------
  // stale data never survives: an unanswered bus shows a changing byte
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_ack <= 1'b0;
      cnt_r <= 4'h0;
      bus_rdata <= 8'h5a;
    end else if (bus_ack || !bus_req_r || cnt_r != ack_wait) begin
      bus_ack <= 1'b0;
      cnt_r <= (bus_ack || !bus_req_r) ? 4'h0 : cnt_r + 4'h1;
      bus_rdata <= ~bus_rdata;
    end else begin
      bus_ack <= 1'b1;
      if (irq_ack_r) bus_rdata <= irq_vec;
      else if (bus_io_r) bus_rdata <= io_val;
      else bus_rdata <= mem[bus_addr_r];
    end
  end
endmodule : cpd_bus_model

// ===== verification/cpu_control_and_port_io_decoder_tb.sv
// Purpose: self-checking bench for cpd_core
// Assumes: each test restarts the core from reset at address 0000
// Notes: every bus transfer is logged; tests judge the log
`timescale 1ns/1ps
module cpu_control_and_port_io_decoder_tb
  import cpd_pkg::*;
;
  typedef struct {logic wr; logic io; logic ak; logic [15:0] a; logic [7:0] d;} cpd_tr_s;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic bus_req_r, bus_wr_r, bus_io_r, bus_ack, irq_ack_r, halted_r, irq_en_r;
  logic [15:0] bus_addr_r, pc_r;
  logic [7:0] bus_wdata_r, bus_rdata;
  logic [1:0] irq_mode_r;
  logic irq_req = 1'b0, reg_ld = 1'b0, ld_en = 1'b0;
  logic [2:0] reg_sel = 3'h0;
  logic [7:0] reg_din = 8'h00, irq_vec = 8'h00, ld_data = 8'h00;
  logic [15:0] ld_addr = 16'h0000;
  logic [3:0] ack_wait = 4'h0;
  cpd_tr_s q[$];
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  // ---------------------------------------------------------------
  // design, far side, clock
  // ---------------------------------------------------------------
  cpd_core i_dut (.clk(clk), .rst_b(rst_b), .bus_req_r(bus_req_r), .bus_wr_r(bus_wr_r),
    .bus_io_r(bus_io_r), .bus_addr_r(bus_addr_r), .bus_wdata_r(bus_wdata_r),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata), .irq_req(irq_req), .irq_ack_r(irq_ack_r),
    .reg_ld(reg_ld), .reg_sel(reg_sel), .reg_din(reg_din), .pc_r(pc_r),
    .halted_r(halted_r), .irq_en_r(irq_en_r), .irq_mode_r(irq_mode_r));
  cpd_bus_model i_bus (.clk(clk), .rst_b(rst_b), .bus_req_r(bus_req_r),
    .bus_wr_r(bus_wr_r), .bus_io_r(bus_io_r), .bus_addr_r(bus_addr_r),
    .bus_wdata_r(bus_wdata_r), .irq_ack_r(irq_ack_r), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .ack_wait(ack_wait), .irq_vec(irq_vec), .ld_en(ld_en),
    .ld_addr(ld_addr), .ld_data(ld_data));
  always #2.5 clk = ~clk;
  // log every finished transfer; flops are sampled before they move
  always @(posedge clk) begin
    if (rst_b && bus_req_r && bus_ack)
      q.push_back('{bus_wr_r, bus_io_r, irq_ack_r, bus_addr_r,
                    bus_wr_r ? bus_wdata_r : bus_rdata});
  end
  // a hang counts as a failure instead of running forever
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask : chk
  // e packs write, io, interrupt ack, address, data
  task automatic chk_tr(input int i, input logic [26:0] e);
    chk({q[i].wr, q[i].io, q[i].ak, q[i].a, q[i].d}, e, "transfer");
  endtask : chk_tr
  // reset is held 16 cycles while the program is loaded
  task automatic begin_test(input logic [7:0] p[$]);
    @(posedge clk);
    rst_b <= 1'b0;
    irq_req <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      ld_en <= 1'b1;
      ld_addr <= 16'(i);
      ld_data <= (i < p.size()) ? p[i] : 8'h76;
      @(posedge clk);
    end
    ld_en <= 1'b0;
    rst_b <= 1'b1;
    q.delete();
  endtask : begin_test
  task automatic pre(input logic [2:0] s, input logic [7:0] v);
    @(posedge clk);
    reg_ld <= 1'b1;
    reg_sel <= s;
    reg_din <= v;
    @(posedge clk);
    reg_ld <= 1'b0;
  endtask : pre
  task automatic load_at(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    ld_en <= 1'b1;
    ld_addr <= a;
    ld_data <= v;
    @(posedge clk);
    ld_en <= 1'b0;
  endtask : load_at
  task automatic wait_halt();
    for (int i = 0; i < 20000 && halted_r !== 1'b1; i++) @(negedge clk);
    chk(halted_r, 1'b1, "halt reached");
  endtask : wait_halt
  task automatic irq_prep(input logic [7:0] op, input logic [1:0] m);
    begin_test('{8'h00, 8'hed, op, 8'hfb, 8'h76});
    chk(irq_mode_r, 2'h0, "mode after reset");
    wait_halt();
    chk(pc_r, 16'h0005, "pc after halt");
    chk(irq_en_r, 1'b1, "unmasked");
    chk(irq_mode_r, m, "mode set");
  endtask : irq_prep
  task automatic irq_fire(input logic [7:0] v, input int n);
    @(posedge clk);
    // the core is halted and idle here, so the log starts at the response read
    q.delete();
    irq_vec <= v;
    irq_req <= 1'b1;
    for (int i = 0; i < 3000 && q.size() < n; i++) @(negedge clk);
    @(posedge clk);
    irq_req <= 1'b0;
    @(negedge clk);
    chk(halted_r, 1'b0, "left halt");
    chk(irq_en_r, 1'b0, "masked on accept");
    chk(q[0].ak, 1'b1, "response read");
  endtask : irq_fire
  // push of pc 0005 high byte first, then fetch at the service address
  task automatic chk_push(input int i, input logic [15:0] t);
    chk_tr(i, {3'h4, 16'hffff, 8'h00});
    chk_tr(i + 1, {3'h4, 16'hfffe, 8'h05});
    chk_tr(i + 2, {3'h0, t, 8'h00});
  endtask : chk_push
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  task automatic t_mask();
    begin_test('{8'hfb, 8'hf3, 8'h76});
    wait_halt();
    chk(irq_en_r, 1'b0, "mask");
    @(posedge clk);
    irq_req <= 1'b1;
    repeat (40) @(negedge clk);
    chk(q.size(), 3, "no accept");
    chk(halted_r, 1'b1, "stays halted");
    $display("test mask done");
  endtask : t_mask
  task automatic t_mode2();
    irq_prep(8'h5e, 2'h2);
    pre(3'h6, 8'h12);
    load_at(16'h1240, 8'h00);
    load_at(16'h1241, 8'h90);
    irq_fire(8'h40, 6);
    chk_tr(1, {3'h0, 16'h1240, 8'h00});
    chk_tr(2, {3'h0, 16'h1241, 8'h90});
    chk_push(3, 16'h9000);
    $display("test mode2 done");
  endtask : t_mode2
  task automatic t_mode1();
    irq_prep(8'h56, 2'h1);
    irq_fire(8'h00, 4); // a device byte that must be ignored
    chk_push(1, 16'h0038);
    $display("test mode1 done");
  endtask : t_mode1
  task automatic t_mode0();
    irq_prep(8'h46, 2'h0);
    irq_fire(8'hff, 4); // device inserts a restart to 0038
    chk_push(1, 16'h0038);
    $display("test mode0 done");
  endtask : t_mode0
  task automatic t_port();
    begin_test('{8'hdb, 8'h55, 8'hd3, 8'h66, 8'hed, 8'h40, 8'hed, 8'h79, 8'h76});
    pre(3'h7, 8'h3c);
    pre(3'h0, 8'h02);
    pre(3'h1, 8'h77);
    wait_halt();
    chk_tr(2, {3'h2, 16'h3c55, 8'h69});
    chk_tr(5, {3'h6, 16'h6966, 8'h69});
    chk_tr(8, {3'h2, 16'h0277, 8'h75});
    chk_tr(11, {3'h6, 16'h7577, 8'h69});
    $display("test port done");
  endtask : t_port
  task automatic t_blk1();
    begin_test('{8'h00, 8'h00, 8'h00, 8'h00, 8'hed, 8'ha2, 8'hed, 8'haa,
                 8'hed, 8'ha3, 8'hed, 8'hab, 8'h76});
    pre(3'h0, 8'h04);
    pre(3'h1, 8'h30);
    pre(3'h4, 8'h30);
    pre(3'h5, 8'h00);
    wait_halt();
    chk_tr(6, {3'h2, 16'h0430, 8'h34});
    chk_tr(7, {3'h4, 16'h3000, 8'h34});
    chk_tr(10, {3'h2, 16'h0330, 8'h33});
    chk_tr(11, {3'h4, 16'h3001, 8'h33});
    chk_tr(14, {3'h0, 16'h3000, 8'h34});
    chk_tr(15, {3'h6, 16'h0230, 8'h34});
    chk_tr(18, {3'h0, 16'h3001, 8'h33});
    chk_tr(19, {3'h6, 16'h0130, 8'h33});
    $display("test block single done");
  endtask : t_blk1
  // slow bus; the repeat-out starts with count 0 and must run 256 times
  task automatic t_blkn();
    int ri[$], wo[$], mw[$];
    logic [7:0] od [4];
    od = '{8'h00, 8'h21, 8'h22, 8'h23};
    begin_test('{8'h00, 8'h00, 8'h00, 8'h00, 8'hed, 8'hb2, 8'hed, 8'hbb, 8'h76});
    ack_wait <= 4'h2;
    pre(3'h0, 8'h03);
    pre(3'h1, 8'h20);
    pre(3'h4, 8'h10);
    pre(3'h5, 8'h00);
    wait_halt();
    foreach (q[i]) begin
      if (q[i].io && q[i].wr) wo.push_back(i);
      else if (q[i].io) ri.push_back(i);
      else if (q[i].wr) mw.push_back(i);
    end
    chk(ri.size(), 3, "repeat reads");
    chk(wo.size(), 256, "repeat writes");
    for (int k = 0; k < 3; k++) begin
      chk_tr(ri[k], {3'h2, 8'h03 - 8'(k), 8'h20, 8'h23 - 8'(k)});
      chk_tr(mw[k], {3'h4, 16'h1000 + 16'(k), 8'h23 - 8'(k)});
    end
    for (int k = 0; k < 4; k++) begin
      chk_tr(wo[k], {3'h6, 8'h00 - 8'(k), 8'h20, od[k]});
    end
    chk_tr(wo[255], {3'h6, 16'h0120, 8'h00});
    $display("test block repeat done");
  endtask : t_blkn
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  // mode tests run from two down so the reset default is really seen
  initial begin
    t_mask();
    t_mode2();
    t_mode1();
    t_mode0();
    t_port();
    t_blk1();
    t_blkn();
    give_verdict();
  end
endmodule : cpu_control_and_port_io_decoder_tb
